// ---- tei_timer_event_irq_dma.sv ----
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Overflow pulses on-chip event when enabled
// - Preset writable; read returns output pin
// - Capture0 flag set by hardware; write captures
// - Capture1 flag likewise, not in bicapture
// - Compare0 flag irq needs global and mask
// - Compare1 flag irq needs global and mask
// - Overflow flag irq needs global and mask
// - Capture0 overrun on repeat or software set
// - Compare0 overrun on repeated request
// - Capture irq combine OR or AND
// - Global enable gates all timer irqs
// - Capture0 DMA mask, cleared at block end
// - Compare0 DMA mask, cleared at block end
// - Separate masks for capture1, compare1, overflow
// - Counter pointer high bits, bit2 swap toggles
// - Channel indicator driven by hardware only
// - Area select and memory segment select
// - Address pointer high bits, bit2 swap toggles
// - Vector upper bits, hardware group code
// - Capture0 end-of-block, forced 1 without swap
// - Compare0 end-of-block, forced 1 without swap
// - Capture source and compare destination selects
// - Swap enable for both DMA channels
// - Three-bit priority level to arbitration
module tei_timer_event_irq_dma
  import tei_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire tei_regbus_type regBus,
  output logic [7:0] rdData_r,
  input wire tei_events_type hwEvent,
  input wire logic bicaptureMode,
  input wire tei_eob_type dmaEob,
  input wire logic timerOutputB,
  output logic softCapture0_r,
  output logic softCapture1_r,
  output logic outbPresetLoad_r,
  output logic outbPresetValue_r,
  output logic onChipEvent_r,
  output logic irqRequest_r,
  output logic [1:0] irqGroup_r,
  output logic dmaRequest_r,
  output logic dmaChannelIndicator_r,
  output logic [2:0] priorityLevel_r,
  output logic dmaAreaRegFile_r,
  output logic dmaMemorySelect_r,
  output logic captureDmaSourceSelect_r,
  output logic compareDmaDestSelect_r
);

  // ==========================================================
  // Storage
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic [7:0] mask_r;
  logic [7:0] mask_nxt;
  logic [7:0] control_r;
  logic [7:0] control_nxt;
  logic [7:0] counterPtr_r;
  logic [7:0] addressPtr_r;
  logic [4:0] vectorHigh_r;
  logic outbEventEnable_r;
  logic outbPreset_r;
  logic pinMeta_r;
  logic pinSync_r;
  tei_chan_type lastChan_r;

  logic wrFlags;
  logic wrMask;
  logic wrControl;
  logic swapOn;
  logic swapToggle;
  logic cap0Ev;
  logic cap1Ev;
  logic cap0SwSet;
  logic cap1SwSet;
  logic cap0Req;
  logic cmp0Req;
  logic capIrq;
  logic cmpIrq;
  logic ovfIrq;
  logic cap0IrqSrc;
  logic cmp0IrqSrc;
  logic capDmaReq;
  logic cmpDmaReq;

  assign wrFlags = regBus.wrEn && regBus.addr == OFS_TIMER_EVENT_FLAGS;
  assign wrMask = regBus.wrEn && regBus.addr == OFS_IRQ_DMA_MASK;
  assign wrControl = regBus.wrEn && regBus.addr == OFS_IRQ_DMA_CONTROL;
  assign swapOn = control_r[CTL_SWAP];

  // ==========================================================
  // Software-simulated captures: a 0-to-1 write acts as a capture
  assign cap0SwSet = wrFlags && regBus.wdata[FLG_CAP0] && !flags_r[FLG_CAP0];
  assign cap1SwSet = wrFlags && regBus.wdata[FLG_CAP1] && !flags_r[FLG_CAP1] && !bicaptureMode;
  assign cap0Ev = hwEvent.capture0 || cap0SwSet;
  assign cap1Ev = hwEvent.capture1 || cap1SwSet;
  assign cap0Req = cap0Ev;
  assign cmp0Req = hwEvent.compare0;
  assign capDmaReq = cap0Req && mask_r[MSK_CAP0_DMA];
  assign cmpDmaReq = cmp0Req && mask_r[MSK_CMP0_DMA];

  // ==========================================================
  // Event flags
  always_comb
  begin
    flags_nxt = flags_r;
    if (wrFlags)
    begin
      // Zeros clear bits 7:1 and ones leave them; the combine bit takes the written value
      flags_nxt[7:1] = flags_r[7:1] & regBus.wdata[7:1];
      flags_nxt[FLG_COMBINE] = regBus.wdata[FLG_COMBINE];
    end
    // Hardware sets come last so they win over a same-cycle clear
    if (cap0Ev)
      flags_nxt[FLG_CAP0] = 1'b1;
    if (cap1Ev)
      flags_nxt[FLG_CAP1] = 1'b1;
    if (hwEvent.compare0)
      flags_nxt[FLG_CMP0] = 1'b1;
    if (hwEvent.compare1)
      flags_nxt[FLG_CMP1] = 1'b1;
    if (hwEvent.ovfUnf)
      flags_nxt[FLG_OVF] = 1'b1;
    if ((cap0Req && flags_r[FLG_CAP0]) || cap0SwSet)
      flags_nxt[FLG_CAP0_OVR] = 1'b1;
    if (cmp0Req && flags_r[FLG_CMP0])
      flags_nxt[FLG_CMP0_OVR] = 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      flags_r <= RST_TIMER_EVENT_FLAGS;
    else
      flags_r <= flags_nxt;
  end

  // ==========================================================
  // Mask register; DMA masks drop at end of block
  always_comb
  begin
    mask_nxt = mask_r;
    if (wrMask)
      mask_nxt = regBus.wdata;
    if (dmaEob.capture0Done)
      mask_nxt[MSK_CAP0_DMA] = 1'b0;
    if (dmaEob.compare0Done)
      mask_nxt[MSK_CMP0_DMA] = 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      mask_r <= RST_IRQ_DMA_MASK;
    else
      mask_r <= mask_nxt;
  end

  // ==========================================================
  // Control register: end-of-block flags, selects, swap, priority
  always_comb
  begin
    control_nxt = control_r;
    if (wrControl)
    begin
      control_nxt[5:0] = regBus.wdata[5:0];
      control_nxt[CTL_CAP0_EOB] = control_r[CTL_CAP0_EOB] & regBus.wdata[CTL_CAP0_EOB];
      control_nxt[CTL_CMP0_EOB] = control_r[CTL_CMP0_EOB] & regBus.wdata[CTL_CMP0_EOB];
    end
    if (dmaEob.capture0Done || !control_nxt[CTL_SWAP])
      control_nxt[CTL_CAP0_EOB] = 1'b1;
    if (dmaEob.compare0Done || !control_nxt[CTL_SWAP])
      control_nxt[CTL_CMP0_EOB] = 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      control_r <= RST_IRQ_DMA_CONTROL;
    else
      control_r <= control_nxt;
  end

  // ==========================================================
  // Pointers; bit 2 flips tables at each swap-mode compare0 block end
  assign swapToggle = swapOn && dmaEob.compare0Done;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      counterPtr_r <= RST_POINTER;
      addressPtr_r <= RST_POINTER;
    end
    else
    begin
      if (regBus.wrEn && regBus.addr == OFS_DMA_COUNTER_POINTER)
      begin
        counterPtr_r[7:2] <= regBus.wdata[7:2];
        counterPtr_r[PTR_AREA] <= regBus.wdata[PTR_AREA];
      end
      else if (swapToggle)
        counterPtr_r[PTR_SWAP_BIT] <= ~counterPtr_r[PTR_SWAP_BIT];
      if (regBus.wrEn && regBus.addr == OFS_DMA_ADDRESS_POINTER)
      begin
        addressPtr_r[7:2] <= regBus.wdata[7:2];
        addressPtr_r[PTR_AREA] <= regBus.wdata[PTR_AREA];
      end
      else if (swapToggle)
        addressPtr_r[PTR_SWAP_BIT] <= ~addressPtr_r[PTR_SWAP_BIT];
    end
  end

  // ==========================================================
  // Vector high bits and output-B control
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      vectorHigh_r <= 5'h00;
      outbEventEnable_r <= 1'b0;
      outbPreset_r <= 1'b0;
      outbPresetLoad_r <= 1'b0;
    end
    else
    begin
      if (regBus.wrEn && regBus.addr == OFS_TIMER_VECTOR)
        vectorHigh_r <= regBus.wdata[7:3];
      outbPresetLoad_r <= 1'b0;
      if (regBus.wrEn && regBus.addr == OFS_OUTB_CONTROL)
      begin
        outbEventEnable_r <= regBus.wdata[OB_EVENT_EN];
        outbPreset_r <= regBus.wdata[OB_PRESET];
        outbPresetLoad_r <= 1'b1;
      end
      else
        outbPreset_r <= pinSync_r;
    end
  end

  assign outbPresetValue_r = outbPreset_r;

  // Pin level is from outside this clock, so two stages first
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pinMeta_r <= 1'b0;
      pinSync_r <= 1'b0;
    end
    else
    begin
      pinMeta_r <= timerOutputB;
      pinSync_r <= pinMeta_r;
    end
  end

  // ==========================================================
  // Interrupt request and group code generation
  // With a DMA mask set, the irq mask selects the end-of-block irq
  assign cap0IrqSrc = mask_r[MSK_CAP0_DMA] ? dmaEob.capture0Done : flags_r[FLG_CAP0];
  assign cmp0IrqSrc = mask_r[MSK_CMP0_DMA] ? dmaEob.compare0Done : flags_r[FLG_CMP0];
  always_comb
  begin
    if (flags_r[FLG_COMBINE])
      capIrq = cap0IrqSrc && mask_r[MSK_CAP0_IRQ] && flags_r[FLG_CAP1] && mask_r[MSK_CAP1_IRQ];
    else
      capIrq = (cap0IrqSrc && mask_r[MSK_CAP0_IRQ]) || (flags_r[FLG_CAP1] && mask_r[MSK_CAP1_IRQ]);
  end
  assign cmpIrq = (cmp0IrqSrc && mask_r[MSK_CMP0_IRQ]) || (flags_r[FLG_CMP1] && mask_r[MSK_CMP1_IRQ]);
  assign ovfIrq = flags_r[FLG_OVF] && mask_r[MSK_OVF_IRQ];

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      irqRequest_r <= 1'b0;
      irqGroup_r <= GRP_OVF;
    end
    else
    begin
      irqRequest_r <= mask_r[MSK_GLOBAL] && (capIrq || cmpIrq || ovfIrq);
      // Fixed group priority: overflow, then capture, then compare
      if (ovfIrq)
        irqGroup_r <= GRP_OVF;
      else if (capIrq)
        irqGroup_r <= GRP_CAPTURE;
      else
        irqGroup_r <= GRP_COMPARE;
    end
  end

  // ==========================================================
  // DMA requests and the hardware-only channel indicator
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      dmaRequest_r <= 1'b0;
      dmaChannelIndicator_r <= 1'b0;
      lastChan_r <= TEI_IDLE;
    end
    else
    begin
      dmaRequest_r <= capDmaReq || cmpDmaReq;
      // Compare0 wins a same-cycle tie; the controller serves one channel at a time
      case (lastChan_r)
        TEI_IDLE, TEI_CAP_DMA, TEI_CMP_DMA:
        begin
          if (cmpDmaReq)
          begin
            lastChan_r <= TEI_CMP_DMA;
            dmaChannelIndicator_r <= 1'b1;
          end
          else if (capDmaReq)
          begin
            lastChan_r <= TEI_CAP_DMA;
            dmaChannelIndicator_r <= 1'b0;
          end
        end
        default:
        begin
          lastChan_r <= TEI_IDLE;
          dmaChannelIndicator_r <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // On-chip event and software capture strobes
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      onChipEvent_r <= 1'b0;
      softCapture0_r <= 1'b0;
      softCapture1_r <= 1'b0;
    end
    else
    begin
      onChipEvent_r <= outbEventEnable_r && hwEvent.ovfUnf;
      softCapture0_r <= cap0SwSet;
      softCapture1_r <= cap1SwSet;
    end
  end

  // ==========================================================
  // Static configuration outputs
  assign priorityLevel_r = control_r[2:0];
  assign dmaAreaRegFile_r = counterPtr_r[PTR_AREA];
  assign dmaMemorySelect_r = addressPtr_r[PTR_AREA];
  assign captureDmaSourceSelect_r = control_r[CTL_CAP_SRC];
  assign compareDmaDestSelect_r = control_r[CTL_CMP_DST];

  // ==========================================================
  // Read port, registered one cycle after rdEn
  always_ff @(posedge clock)
  begin
    if (srst)
      rdData_r <= 8'h00;
    else if (regBus.rdEn)
    begin
      case (regBus.addr)
        OFS_DMA_COUNTER_POINTER: rdData_r <= {counterPtr_r[7:2], dmaChannelIndicator_r, counterPtr_r[PTR_AREA]};
        OFS_DMA_ADDRESS_POINTER: rdData_r <= {addressPtr_r[7:2], dmaChannelIndicator_r, addressPtr_r[PTR_AREA]};
        OFS_TIMER_VECTOR: rdData_r <= {vectorHigh_r, irqGroup_r, 1'b0};
        OFS_IRQ_DMA_CONTROL: rdData_r <= control_r;
        OFS_OUTB_CONTROL: rdData_r <= {6'h00, outbEventEnable_r, pinSync_r};
        OFS_TIMER_EVENT_FLAGS: rdData_r <= flags_r;
        OFS_IRQ_DMA_MASK: rdData_r <= mask_r;
        default: rdData_r <= 8'h00;
      endcase
    end
  end

endmodule : tei_timer_event_irq_dma
`default_nettype wire

// ---- tei_pkg.sv ----
package tei_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_DMA_COUNTER_POINTER = 8'hF0;
  localparam logic [7:0] OFS_DMA_ADDRESS_POINTER = 8'hF1;
  localparam logic [7:0] OFS_TIMER_VECTOR = 8'hF2;
  localparam logic [7:0] OFS_IRQ_DMA_CONTROL = 8'hF3;
  localparam logic [7:0] OFS_OUTB_CONTROL = 8'hFD;
  localparam logic [7:0] OFS_TIMER_EVENT_FLAGS = 8'hFE;
  localparam logic [7:0] OFS_IRQ_DMA_MASK = 8'hFF;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_IRQ_DMA_CONTROL = 8'hC7;
  localparam logic [7:0] RST_TIMER_EVENT_FLAGS = 8'h00;
  localparam logic [7:0] RST_IRQ_DMA_MASK = 8'h00;
  localparam logic [7:0] RST_POINTER = 8'h00;
  localparam logic [7:0] RST_OUTB_CONTROL = 8'h00;

  // ==========================================================
  // Field positions
  localparam int FLG_CAP0 = 7;
  localparam int FLG_CAP1 = 6;
  localparam int FLG_CMP0 = 5;
  localparam int FLG_CMP1 = 4;
  localparam int FLG_OVF = 3;
  localparam int FLG_CAP0_OVR = 2;
  localparam int FLG_CMP0_OVR = 1;
  localparam int FLG_COMBINE = 0;
  localparam int MSK_GLOBAL = 7;
  localparam int MSK_CAP0_DMA = 6;
  localparam int MSK_CAP0_IRQ = 5;
  localparam int MSK_CAP1_IRQ = 4;
  localparam int MSK_CMP0_DMA = 3;
  localparam int MSK_CMP0_IRQ = 2;
  localparam int MSK_CMP1_IRQ = 1;
  localparam int MSK_OVF_IRQ = 0;
  localparam int CTL_CAP0_EOB = 7;
  localparam int CTL_CMP0_EOB = 6;
  localparam int CTL_CAP_SRC = 5;
  localparam int CTL_CMP_DST = 4;
  localparam int CTL_SWAP = 3;
  localparam int PTR_SWAP_BIT = 2;
  localparam int PTR_CHANNEL = 1;
  localparam int PTR_AREA = 0;
  localparam int OB_EVENT_EN = 1;
  localparam int OB_PRESET = 0;

  // ==========================================================
  // Vector group codes
  localparam logic [1:0] GRP_OVF = 2'h0;
  localparam logic [1:0] GRP_CAPTURE = 2'h2;
  localparam logic [1:0] GRP_COMPARE = 2'h3;

  typedef struct packed {
    logic capture0;
    logic capture1;
    logic compare0;
    logic compare1;
    logic ovfUnf;
  } tei_events_type;

  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tei_regbus_type;

  typedef struct packed {
    logic capture0Done;
    logic compare0Done;
  } tei_eob_type;

  typedef enum logic [1:0] {
    TEI_IDLE,
    TEI_CAP_DMA,
    TEI_CMP_DMA
  } tei_chan_type;

endpackage : tei_pkg

// ---- tei_asserts.sv ----
`timescale 1ns/1ns
`default_nettype none
module tei_asserts
  import tei_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire tei_regbus_type regBus,
  input wire tei_events_type hwEvent,
  input wire logic bicaptureMode,
  input wire logic [7:0] rdData_r,
  input wire logic softCapture0_r,
  input wire logic softCapture1_r,
  input wire logic onChipEvent_r,
  input wire logic [1:0] irqGroup_r,
  input wire logic dmaRequest_r,
  input wire logic dmaChannelIndicator_r,
  input wire logic [2:0] priorityLevel_r
);
  // ==========================================================
  // Decode helpers
  logic rdVec;
  logic wrFlags;
  logic wrCtl;
  assign rdVec = regBus.rdEn && regBus.addr == OFS_TIMER_VECTOR;
  assign wrFlags = regBus.wrEn && regBus.addr == OFS_TIMER_EVENT_FLAGS;
  assign wrCtl = regBus.wrEn && regBus.addr == OFS_IRQ_DMA_CONTROL;
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (srst);
  // ==========================================================
  // Properties
  property p_evt_cause;
    onChipEvent_r |-> $past(hwEvent.ovfUnf);
  endproperty
  a_evt_cause: assert property (p_evt_cause) else $error("event pulse without overflow");
  property p_evt_single;
    onChipEvent_r && !hwEvent.ovfUnf |=> !onChipEvent_r;
  endproperty
  a_evt_single: assert property (p_evt_single) else $error("event pulse too long");
  property p_dma_cause;
    dmaRequest_r |-> $past(hwEvent.capture0 || hwEvent.compare0);
  endproperty
  a_dma_cause: assert property (p_dma_cause) else $error("dma request without event");
  property p_chan;
    dmaRequest_r && $past(hwEvent.capture0 != hwEvent.compare0) |-> dmaChannelIndicator_r == $past(hwEvent.compare0);
  endproperty
  a_chan: assert property (p_chan) else $error("wrong dma channel");
  property p_vec;
    rdVec |=> rdData_r[0] == 1'b0 && rdData_r[2:1] != 2'h1;
  endproperty
  a_vec: assert property (p_vec) else $error("bad vector low bits");
  property p_grp;
    irqGroup_r != 2'h1;
  endproperty
  a_grp: assert property (p_grp) else $error("unused group code");
  property p_prio;
    wrCtl |=> priorityLevel_r == $past(regBus.wdata[2:0]);
  endproperty
  a_prio: assert property (p_prio) else $error("priority not loaded");
  property p_soft0;
    $rose(softCapture0_r) |-> $past(wrFlags && regBus.wdata[FLG_CAP0]);
  endproperty
  a_soft0: assert property (p_soft0) else $error("stray capture0 request");
  property p_soft1;
    softCapture1_r |-> $past(wrFlags && regBus.wdata[FLG_CAP1] && !bicaptureMode);
  endproperty
  a_soft1: assert property (p_soft1) else $error("stray capture1 request");
endmodule : tei_asserts
bind tei_timer_event_irq_dma tei_asserts u_asserts (.clock, .srst, .regBus, .hwEvent, .bicaptureMode,
  .rdData_r, .softCapture0_r, .softCapture1_r, .onChipEvent_r, .irqGroup_r, .dmaRequest_r,
  .dmaChannelIndicator_r, .priorityLevel_r);
`default_nettype wire

// ---- tei_partner.sv ----
`timescale 1ns/1ns
`default_nettype none
module tei_partner
  import tei_pkg::*;
#(
  parameter int BLOCK_LEN = 2
)
(
  input wire logic clock,
  input wire logic srst,
  input wire logic dmaReq,
  input wire logic dmaChan,
  output tei_eob_type eob
);
  // ==========================================================
  // Block counter; a short block keeps end-of-block cheap to reach
  logic [3:0] cnt_r;
  always_ff @(posedge clock)
  begin
    eob <= '0;
    if (srst)
      cnt_r <= 4'h0;
    else if (dmaReq)
    begin
      if (cnt_r == 4'(BLOCK_LEN - 1))
      begin
        cnt_r <= 4'h0;
        eob.capture0Done <= !dmaChan;
        eob.compare0Done <= dmaChan;
      end
      else
        cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule : tei_partner
`default_nettype wire

// ---- test_timer_event_irq_dma.sv ----
`timescale 1ns/1ns
`default_nettype none
module test_timer_event_irq_dma;
  import tei_pkg::*;
  localparam tei_events_type EV_OVF = 5'h01;
  localparam tei_events_type EV_M1 = 5'h02;
  localparam tei_events_type EV_M0 = 5'h04;
  localparam tei_events_type EV_P1 = 5'h08;
  localparam tei_events_type EV_P0 = 5'h10;
  logic clock = 1'b0;
  logic srst = 1'b1;
  tei_regbus_type regBus = '0;
  tei_events_type hwEvent = '0;
  logic bicaptureMode = 1'b0;
  logic timerOutputB = 1'b0;
  tei_eob_type dmaEob;
  logic [7:0] rdData_r;
  logic [7:0] r;
  logic [7:0] expQ[$];
  logic [1:0] irqGroup_r;
  logic [2:0] priorityLevel_r;
  logic softCapture0_r, softCapture1_r, outbPresetLoad_r, outbPresetValue_r, onChipEvent_r;
  logic irqRequest_r, dmaRequest_r, dmaChannelIndicator_r, dmaAreaRegFile_r, dmaMemorySelect_r;
  logic captureDmaSourceSelect_r, compareDmaDestSelect_r;
  logic rdPend = 1'b0;
  int fail_count = 0;
  int checked = 0;
  always #5 clock = ~clock;
  tei_timer_event_irq_dma dut (.clock, .srst, .regBus, .rdData_r, .hwEvent, .bicaptureMode, .dmaEob,
    .timerOutputB, .softCapture0_r, .softCapture1_r, .outbPresetLoad_r, .outbPresetValue_r,
    .onChipEvent_r, .irqRequest_r, .irqGroup_r, .dmaRequest_r, .dmaChannelIndicator_r,
    .priorityLevel_r, .dmaAreaRegFile_r, .dmaMemorySelect_r, .captureDmaSourceSelect_r,
    .compareDmaDestSelect_r);
  tei_partner #(.BLOCK_LEN(2)) u_far (.clock, .srst, .dmaReq(dmaRequest_r), .dmaChan(dmaChannelIndicator_r),
    .eob(dmaEob));
  // ==========================================================
  // Tasks
  task check(input string nm, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task conclude;
    if (expQ.size() != 0)
      fail_count++;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude
  // One bus cycle per call, so back-to-back calls never touch a strobe twice in one step
  task op(input logic [1:0] k, input logic [7:0] a = 8'h00, input logic [7:0] d = 8'h00,
    input tei_events_type ev = '0);
    @(negedge clock);
    regBus = '{k[1], k[0], a, d};
    hwEvent = ev;
  endtask : op
  task wr(input logic [7:0] a, input logic [7:0] d);
    op(2'h2, a, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    op(2'h1, a);
  endtask : rd
  task cyc(input int n);
    repeat (n) op(2'h0);
  endtask : cyc
  task ev(input tei_events_type e);
    op(2'h0, 8'h00, 8'h00, e);
  endtask : ev
  // ==========================================================
  // Read monitor
  always @(posedge clock) rdPend <= regBus.rdEn;
  always @(negedge clock)
  begin
    if (rdPend && expQ.size() > 0)
      check("rdData", rdData_r, expQ.pop_front());
  end
  initial
  begin
    #200000;
    fail_count++;
    conclude();
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    r = $urandom(32'h534D0201);
    repeat (6) @(posedge clock);
    @(negedge clock);
    srst = 1'b0;
    rd(8'hFE, 8'h00);
    rd(8'hFF, 8'h00);
    rd(8'hF3, 8'hC7);
    rd(8'hFD, 8'h00);
    rd(8'h10, 8'h00);
    wr(8'hFF, 8'h81);
    wr(8'hFD, 8'h02);
    ev(EV_OVF);
    cyc(1);
    check("evt", onChipEvent_r, 8'h01);
    cyc(1);
    check("irq", irqRequest_r, 8'h01);
    check("grp", irqGroup_r, 8'h00);
    rd(8'hFE, 8'h08);
    r = $urandom;
    wr(8'hF2, r);
    rd(8'hF2, r & 8'hF8);
    wr(8'hFF, 8'h01);
    cyc(2);
    check("irq", irqRequest_r, 8'h00);
    wr(8'hFF, 8'h80);
    cyc(2);
    check("irq", irqRequest_r, 8'h00);
    wr(8'hFF, 8'h81);
    cyc(2);
    check("irq", irqRequest_r, 8'h01);
    wr(8'hFE, 8'h00);
    cyc(2);
    check("irq", irqRequest_r, 8'h00);
    wr(8'hFD, 8'h01);
    ev(EV_OVF);
    check("load", outbPresetLoad_r, 8'h01);
    check("preset", outbPresetValue_r, 8'h01);
    cyc(1);
    check("evt", onChipEvent_r, 8'h00);
    check("preset", outbPresetValue_r, 8'h00);
    check("load", outbPresetLoad_r, 8'h00);
    timerOutputB = 1'b1;
    cyc(3);
    check("preset", outbPresetValue_r, 8'h01);
    rd(8'hFD, 8'h01);
    wr(8'hFE, 8'h00);
    ev(EV_M0);
    ev(EV_M0);
    rd(8'hFE, 8'h22);
    op(2'h2, 8'hFE, 8'h00, EV_M1);
    rd(8'hFE, 8'h10);
    wr(8'hFE, 8'h80);
    rd(8'hFE, 8'h84);
    bicaptureMode = 1'b1;
    wr(8'hFE, 8'h40);
    rd(8'hFE, 8'h00);
    bicaptureMode = 1'b0;
    wr(8'hFE, 8'h40);
    rd(8'hFE, 8'h40);
    wr(8'hFF, 8'hB0);
    wr(8'hFE, 8'h01);
    ev(EV_P0);
    cyc(2);
    check("irq", irqRequest_r, 8'h00);
    ev(EV_P1);
    cyc(2);
    check("irq", irqRequest_r, 8'h01);
    check("grp", irqGroup_r, 8'h02);
    wr(8'hFE, 8'h00);
    wr(8'hFF, 8'h48);
    wr(8'hF3, 8'h08);
    wr(8'hF0, 8'h00);
    wr(8'hF1, 8'h00);
    ev(EV_M0);
    ev(EV_M0);
    cyc(3);
    rd(8'hFF, 8'h40);
    rd(8'hF0, 8'h06);
    rd(8'hF1, 8'h06);
    rd(8'hF3, 8'h48);
    ev(EV_P0);
    ev(EV_P0);
    cyc(3);
    rd(8'hFF, 8'h00);
    rd(8'hF3, 8'hC8);
    rd(8'hF0, 8'h04);
    for (int i = 0; i < 3; i++)
    begin
      r = $urandom;
      wr(8'hF3, r & 8'hF7);
      rd(8'hF3, (r | 8'hC0) & 8'hF7);
      check("prio", priorityLevel_r, r[2:0]);
      check("src", captureDmaSourceSelect_r, r[5]);
      check("dst", compareDmaDestSelect_r, r[4]);
      wr(8'hF0, r);
      wr(8'hF1, r);
      rd(8'hF0, r & 8'hFD);
      rd(8'hF1, r & 8'hFD);
      check("area", dmaAreaRegFile_r, r[0]);
      check("mem", dmaMemorySelect_r, r[0]);
    end
    cyc(2);
    conclude();
  end
endmodule : test_timer_event_irq_dma
`default_nettype wire
